// ---- shared/ptir_pkg.sv ----
// Package: offsets, encodings and identity defaults for the telemetry/identity bank
package ptir_pkg;
   localparam int          ADDR_W          = 10;
   localparam int          DATA_W          = 16;
   // Register addresses
   localparam logic [9:0]  OFF_VIN         = 10'h310;
   localparam logic [9:0]  OFF_IIN         = 10'h312;
   localparam logic [9:0]  OFF_VOUT        = 10'h316;
   localparam logic [9:0]  OFF_IOUT        = 10'h318;
   localparam logic [9:0]  OFF_TEMP        = 10'h31a;
   localparam logic [9:0]  OFF_POUT        = 10'h32c;
   localparam logic [9:0]  OFF_PIN         = 10'h32e;
   localparam logic [9:0]  OFF_PROTO_REV   = 10'h330;
   localparam logic [9:0]  OFF_MAKER_ID    = 10'h332;
   localparam logic [9:0]  OFF_MODEL       = 10'h334;
   localparam logic [9:0]  OFF_MAKER_REV   = 10'h336;
   localparam logic [9:0]  OFF_PART_ID     = 10'h35a;
   localparam logic [9:0]  OFF_SI_REV      = 10'h35c;
   localparam logic [9:0]  OFF_PROD_INFO   = 10'h382;
   localparam logic [9:0]  OFF_SCRATCH     = 10'h384;
   localparam logic [9:0]  OFF_IND_PTR     = 10'h3a0;
   localparam logic [9:0]  OFF_IND_DATA    = 10'h3a2;
   // Reset values
   localparam logic [15:0] SCRATCH_RST     = 16'h0000;
   localparam logic [15:0] ZERO_WORD       = 16'h0000;
   localparam logic [7:0]  ZERO_BYTE       = 8'h00;
   // Protocol revision byte: part one 1.1 high nibble, part two 1.2 low nibble
   localparam logic [3:0]  PROTO_P1_REV    = 4'h1;
   localparam logic [3:0]  PROTO_P2_REV    = 4'h2;
   // Identity defaults, values arbitrary
   localparam logic [15:0] MAKER_ID_DFLT   = 16'h5a5a;
   localparam logic [7:0]  PART_ID_CODE    = 8'h3c;
   localparam logic [7:0]  SI_REV_CODE     = 8'h01;
   // Fixed telemetry exponents (five-bit two's complement)
   localparam logic [4:0]  EXP_VIN         = 5'h1c;
   localparam logic [4:0]  EXP_IIN         = 5'h1e;
   localparam logic [4:0]  EXP_IOUT        = 5'h1e;
   localparam logic [4:0]  EXP_TEMP        = 5'h00;
   localparam logic [4:0]  EXP_POUT        = 5'h1f;
   localparam logic [4:0]  EXP_PIN         = 5'h1f;
   localparam logic [4:0]  EXP_VOUT_MEAS   = 5'h14;
   // Mode field layout
   localparam int          MODE_EXP_MSB    = 4;
   localparam int          MANT_W          = 11;
   localparam int          EXP_W           = 5;
endpackage : ptir_pkg

// ---- hw/ptir_regs.sv ----
// Telemetry and identity register bank with power-good threshold compare
`timescale 1ns/10ps

// Notes on behaviour
// - Input voltage word returns measured volts in linear encoding.
// - Input current word returns measured amperes in linear encoding.
// - Output voltage word follows exponent chosen by output mode setting.
// - Output current word returns measured amperes in linear encoding.
// - Temperature word returns thermistor sensor reading in degrees Celsius.
// - Output power word returns computed watts in linear encoding.
// - Input power word returns computed watts in linear encoding.
// - Protocol revision byte reports part one 1.1, part two 1.2.
// - Maker identity: two bytes, host-written value, else stored user value, else default code.
// - Model byte is part identity when user field zero, else user value.
// - Maker revision is silicon revision when user field zero, else user.
// - Part identity read returns one fixed variant code byte.
// - Silicon revision read returns the internally held revision.
// - Product info word carries part identity and silicon revision.
// - Vendor scratch word is read/write and resets to zero.
// - Halving output scale compares power-good thresholds at half value.
// - Telemetry other than output voltage packs signed mantissa and signed exponent in one word.
// - Output voltage words carry only unsigned mantissa, exponent from mode.
module ptir_regs (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   input  wire logic [ptir_pkg::ADDR_W-1:0] i_addr,
   input  wire logic                       i_rd,
   input  wire logic                       i_wr,
   input  wire logic [ptir_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_cml_clear,
   input  wire logic [10:0]                i_vin_mant,
   input  wire logic [10:0]                i_iin_mant,
   input  wire logic [15:0]                i_vout_meas,
   input  wire logic [10:0]                i_iout_mant,
   input  wire logic [10:0]                i_temp_mant,
   input  wire logic [10:0]                i_pout_mant,
   input  wire logic [10:0]                i_pin_mant,
   input  wire logic [7:0]                 i_vout_mode,
   input  wire logic                       i_vout_scale_half,
   input  wire logic [15:0]                i_pg_assert_thresh,
   input  wire logic [15:0]                i_pg_deassert_thresh,
   input  wire logic                       i_user_maker_valid,
   input  wire logic [15:0]                i_user_maker_id,
   input  wire logic [7:0]                 i_user_model,
   input  wire logic [15:0]                i_user_revision,
   output logic      [ptir_pkg::DATA_W-1:0] o_rdata,
   output logic                            o_rvalid,
   output logic                            o_cml_invalid,
   output logic                            o_power_good
);
   import ptir_pkg::*;

   typedef struct packed {
      logic [15:0] rdata;
      logic        rvalid;
      logic        cml;
      logic        pg;
      logic [15:0] maker_id;
      logic        maker_wr;
      logic [15:0] scratch;
      logic [9:0]  ind_ptr;
   } ptir_state_t;

   ptir_state_t state_reg;
   ptir_state_t state_next;

   logic [15:0] vout_word;
   logic [15:0] pg_on_eff;
   logic [15:0] pg_off_eff;
   logic [16:0] dir_hit;
   logic [16:0] ind_hit;
   logic        dir_wr_ok;
   logic        ind_wr_ok;

   // Signed mantissa times two to a signed exponent, one word
   function automatic logic [15:0] lin11(input logic [4:0] e, input logic [10:0] m);
      lin11 = {e, m};
   endfunction : lin11

   // Rescale measured output voltage to the mode exponent, unsigned mantissa only
   function automatic logic [15:0] to_mode(input logic [15:0] meas, input logic [4:0] n);
      int sh;
      sh = int'($signed(n)) - int'($signed(EXP_VOUT_MEAS));
      if (sh >= 0) begin
         to_mode = meas >> sh;
      end else begin
         to_mode = meas << (-sh);
      end
   endfunction : to_mode

   // Read decode shared by direct and indirect access; bit 16 marks a mapped word
   function automatic logic [16:0] rd_decode(input logic [9:0] a, input ptir_state_t s);
      rd_decode = {1'b1, ZERO_WORD};
      unique case (a)
         OFF_VIN:       rd_decode[15:0] = lin11(EXP_VIN, i_vin_mant);
         OFF_IIN:       rd_decode[15:0] = lin11(EXP_IIN, i_iin_mant);
         OFF_VOUT:      rd_decode[15:0] = vout_word;
         OFF_IOUT:      rd_decode[15:0] = lin11(EXP_IOUT, i_iout_mant);
         OFF_TEMP:      rd_decode[15:0] = lin11(EXP_TEMP, i_temp_mant);
         OFF_POUT:      rd_decode[15:0] = lin11(EXP_POUT, i_pout_mant);
         OFF_PIN:       rd_decode[15:0] = lin11(EXP_PIN, i_pin_mant);
         OFF_PROTO_REV: rd_decode[15:0] = {ZERO_BYTE, PROTO_P1_REV, PROTO_P2_REV};
         OFF_MAKER_ID: begin
            if (s.maker_wr) begin
               rd_decode[15:0] = s.maker_id;
            end else if (i_user_maker_valid) begin
               rd_decode[15:0] = i_user_maker_id;
            end else begin
               rd_decode[15:0] = MAKER_ID_DFLT;
            end
         end
         OFF_MODEL: begin
            if (i_user_model == ZERO_BYTE) begin
               rd_decode[15:0] = {ZERO_BYTE, PART_ID_CODE};
            end else begin
               rd_decode[15:0] = {ZERO_BYTE, i_user_model};
            end
         end
         OFF_MAKER_REV: begin
            if (i_user_revision == ZERO_WORD) begin
               rd_decode[15:0] = {ZERO_BYTE, SI_REV_CODE};
            end else begin
               rd_decode[15:0] = i_user_revision;
            end
         end
         OFF_PART_ID:   rd_decode[15:0] = {ZERO_BYTE, PART_ID_CODE};
         OFF_SI_REV:    rd_decode[15:0] = {ZERO_BYTE, SI_REV_CODE};
         OFF_PROD_INFO: rd_decode[15:0] = {PART_ID_CODE, SI_REV_CODE};
         OFF_SCRATCH:   rd_decode[15:0] = s.scratch;
         OFF_IND_PTR:   rd_decode[15:0] = {6'h00, s.ind_ptr};
         default:       rd_decode       = {1'b0, ZERO_WORD};
      endcase
   endfunction : rd_decode

   // Only the maker identity, scratch and indirect pointer take writes
   function automatic logic wr_allowed(input logic [9:0] a);
      wr_allowed = (a == OFF_MAKER_ID) || (a == OFF_SCRATCH) || (a == OFF_IND_PTR);
   endfunction : wr_allowed

   always_comb begin
      vout_word  = to_mode(i_vout_meas, i_vout_mode[MODE_EXP_MSB:0]);
      // Thresholds share the output voltage format; halving mode halves them
      pg_on_eff  = i_vout_scale_half ? (i_pg_assert_thresh >> 1) : i_pg_assert_thresh;
      pg_off_eff = i_vout_scale_half ? (i_pg_deassert_thresh >> 1) : i_pg_deassert_thresh;
      dir_hit    = rd_decode(i_addr, state_reg);
      ind_hit    = rd_decode(state_reg.ind_ptr, state_reg);
      dir_wr_ok  = wr_allowed(i_addr);
      ind_wr_ok  = wr_allowed(state_reg.ind_ptr) && (state_reg.ind_ptr != OFF_IND_PTR);
   end

   always_comb begin
      state_next        = state_reg;
      state_next.rvalid = 1'b0;
      // Hysteresis: assert at the on level, drop below the off level
      if (!state_reg.pg && (vout_word >= pg_on_eff)) begin
         state_next.pg = 1'b1;
      end else if (state_reg.pg && (vout_word < pg_off_eff)) begin
         state_next.pg = 1'b0;
      end
      if (i_cml_clear) begin
         state_next.cml = 1'b0;
      end
      if (i_rd) begin
         state_next.rvalid = 1'b1;
         if (i_addr == OFF_IND_DATA) begin
            state_next.rdata = ind_hit[15:0];
            if (!ind_hit[16]) begin
               state_next.cml = 1'b1;
            end
         end else begin
            state_next.rdata = dir_hit[15:0];
            if (!dir_hit[16]) begin
               state_next.cml = 1'b1;
            end
         end
      end else if (i_wr) begin
         // Write through the pointer reuses the same permission check, except that the pointer itself is refused
         if (i_addr == OFF_IND_DATA) begin
            if (ind_wr_ok) begin
               unique case (state_reg.ind_ptr)
                  OFF_MAKER_ID: begin
                     state_next.maker_id = i_wdata;
                     state_next.maker_wr = 1'b1;
                  end
                  default: state_next.scratch = i_wdata;
               endcase
            end else begin
               state_next.cml = 1'b1;
            end
         end else if (dir_wr_ok) begin
            unique case (i_addr)
               OFF_MAKER_ID: begin
                  state_next.maker_id = i_wdata;
                  state_next.maker_wr = 1'b1;
               end
               OFF_SCRATCH: state_next.scratch = i_wdata;
               default:     state_next.ind_ptr = i_wdata[ADDR_W-1:0];
            endcase
         end else begin
            state_next.cml = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg          <= '0;
         state_reg.scratch  <= SCRATCH_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_rdata       = state_reg.rdata;
   assign o_rvalid      = state_reg.rvalid;
   assign o_cml_invalid = state_reg.cml;
   assign o_power_good  = state_reg.pg;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   property p_vin_read;
      i_rd && (i_addr == OFF_VIN) |=> o_rvalid &&
         (o_rdata == {EXP_VIN, $past(i_vin_mant)});
   endproperty
   a_vin_read: assert property (p_vin_read) else $error("input voltage word wrong");

   property p_temp_read;
      i_rd && (i_addr == OFF_TEMP) |=> (o_rdata == {EXP_TEMP, $past(i_temp_mant)});
   endproperty
   a_temp_read: assert property (p_temp_read) else $error("temperature word wrong");

   property p_proto_rev;
      i_rd && (i_addr == OFF_PROTO_REV) |=> (o_rdata[7:0] == {PROTO_P1_REV, PROTO_P2_REV});
   endproperty
   a_proto_rev: assert property (p_proto_rev) else $error("protocol revision wrong");

   property p_model;
      i_rd && (i_addr == OFF_MODEL) && (i_user_model == ZERO_BYTE)
         |=> (o_rdata[7:0] == PART_ID_CODE);
   endproperty
   a_model: assert property (p_model) else $error("model default wrong");

   property p_prod_info;
      i_rd && (i_addr == OFF_PROD_INFO) |=> (o_rdata == {PART_ID_CODE, SI_REV_CODE});
   endproperty
   a_prod_info: assert property (p_prod_info) else $error("product info wrong");

   property p_scratch_rt;
      i_wr && (i_addr == OFF_SCRATCH) ##1 (i_rd && (i_addr == OFF_SCRATCH) && !i_wr)
         |=> (o_rdata == $past(i_wdata, 2));
   endproperty
   a_scratch_rt: assert property (p_scratch_rt) else $error("scratch not stored");

   property p_ro_write;
      i_wr && !i_rd && (i_addr == OFF_VIN) |=> o_cml_invalid && $stable(state_reg.scratch);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("read-only write not flagged");

   property p_pg_half;
      i_vout_scale_half && !o_power_good && (vout_word >= (i_pg_assert_thresh >> 1))
         |=> o_power_good;
   endproperty
   a_pg_half: assert property (p_pg_half) else $error("half threshold not applied");

   property p_vout_linear;
      i_rd && (i_addr == OFF_VOUT) && (i_vout_mode[MODE_EXP_MSB:0] == EXP_VOUT_MEAS)
         |=> (o_rdata == $past(i_vout_meas));
   endproperty
   a_vout_linear: assert property (p_vout_linear) else $error("output voltage word wrong");

   property p_rvalid_pulse;
      o_rvalid |-> $past(i_rd);
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("answer without request");

   c_ind_read: cover property (i_wr && (i_addr == OFF_IND_PTR) ##1 i_rd && (i_addr == OFF_IND_DATA));
   c_pg_cycle: cover property (o_power_good ##[1:20] !o_power_good);
   c_maker_wr: cover property (i_wr && (i_addr == OFF_MAKER_ID) ##1 i_rd && (i_addr == OFF_MAKER_ID));
endmodule : ptir_regs

// ---- dv/ptir_host.sv ----
// Host-side requester model for the telemetry and identity register port
`timescale 1ns/10ps
module ptir_host (
   input  wire logic        i_clk,
   output logic      [9:0]  o_addr,
   output logic             o_rd,
   output logic             o_wr,
   output logic      [15:0] o_wdata,
   output logic             o_scale_half,
   output logic      [15:0] o_pg_on,
   output logic      [15:0] o_pg_off
);
   initial begin
      o_addr       = 10'h000;
      o_rd         = 1'b0;
      o_wr         = 1'b0;
      o_wdata      = 16'h0000;
      o_scale_half = 1'b0;
      o_pg_on      = 16'hffff;
      o_pg_off     = 16'hffff;
   end
   // One request per call; successive calls run back to back
   task automatic req(input logic wr, input logic [9:0] a, input logic [15:0] d);
      @(posedge i_clk);
      #1;
      o_rd    = ~wr;
      o_wr    = wr;
      o_addr  = a;
      o_wdata = d;
   endtask : req
   // Released bus shows inverted leftovers, never stale values
   task automatic idle();
      @(posedge i_clk);
      #1;
      o_rd    = 1'b0;
      o_wr    = 1'b0;
      o_addr  = ~o_addr;
      o_wdata = ~o_wdata;
   endtask : idle
   // Doubled thresholds so the halved compare lands on the wanted level
   task automatic set_pg(input logic half, input logic [15:0] on, input logic [15:0] off);
      o_scale_half = half;
      o_pg_on      = half ? {on[14:0], 1'b0} : on;
      o_pg_off     = half ? {off[14:0], 1'b0} : off;
   endtask : set_pg
endmodule : ptir_host

// ---- dv/tb_top.sv ----
// Self-checking bench for the telemetry and identity register bank
`timescale 1ns/10ps
module tb_top;
   import ptir_pkg::*;
   localparam logic [9:0]  TEL_A [6] = '{OFF_VIN, OFF_IIN, OFF_IOUT, OFF_TEMP, OFF_POUT, OFF_PIN};
   localparam logic [4:0]  TEL_E [6] = '{EXP_VIN, EXP_IIN, EXP_IOUT, EXP_TEMP, EXP_POUT, EXP_PIN};
   localparam logic [4:0]  NMODE [4] = '{5'h14, 5'h17, 5'h13, 5'h18};
   localparam logic        PG_H [5]  = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   localparam logic [15:0] PG_M [5]  = '{16'h0500, 16'h0200, 16'h0380, 16'h0500, 16'h0380};
   localparam logic        PG_E [5]  = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
   logic        i_clk, i_rst_n, i_cml_clear, i_user_maker_valid, h_rd, h_wr, h_half;
   logic [9:0]  h_addr;
   logic [10:0] mant [6];
   logic [15:0] h_wdata, h_on, h_off, i_vout_meas, i_user_maker_id, i_user_revision, seed, d;
   logic [7:0]  i_vout_mode, i_user_model;
   logic [15:0] o_rdata;
   logic        o_rvalid, o_cml_invalid, o_power_good;
   logic [15:0] exp_q [$];
   int          fails, total_checks;

   ptir_host i_ptir_host (.i_clk(i_clk), .o_addr(h_addr), .o_rd(h_rd), .o_wr(h_wr),
      .o_wdata(h_wdata), .o_scale_half(h_half), .o_pg_on(h_on), .o_pg_off(h_off));
   ptir_regs i_ptir_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(h_addr), .i_rd(h_rd),
      .i_wr(h_wr), .i_wdata(h_wdata), .i_cml_clear(i_cml_clear), .i_vin_mant(mant[0]),
      .i_iin_mant(mant[1]), .i_vout_meas(i_vout_meas), .i_iout_mant(mant[2]),
      .i_temp_mant(mant[3]), .i_pout_mant(mant[4]), .i_pin_mant(mant[5]),
      .i_vout_mode(i_vout_mode), .i_vout_scale_half(h_half), .i_pg_assert_thresh(h_on),
      .i_pg_deassert_thresh(h_off), .i_user_maker_valid(i_user_maker_valid),
      .i_user_maker_id(i_user_maker_id), .i_user_model(i_user_model),
      .i_user_revision(i_user_revision), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
      .o_cml_invalid(o_cml_invalid), .o_power_good(o_power_good));

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction : rnd
   // Output voltage rescaled from the fixed measurement exponent to the mode exponent
   function automatic logic [15:0] vexp(input logic [15:0] m, input logic [4:0] n);
      int k;
      k = int'($signed(n)) + 12;
      return (k >= 0) ? (m >> k) : (m << (-k));
   endfunction : vexp
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      total_checks++;
      if (seen !== expv) begin
         fails++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : check
   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      i_ptir_host.req(1'b0, a, 16'h0000);
   endtask : rd
   task automatic wr(input logic [9:0] a, input logic [15:0] v);
      i_ptir_host.req(1'b1, a, v);
   endtask : wr
   // Every queued answer must have arrived by now
   task automatic settle();
      i_ptir_host.idle();
      repeat (2) @(posedge i_clk);
      #1;
      check(16'(exp_q.size()), 16'h0000);
   endtask : settle
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // Answers sampled mid-cycle, well clear of the launching edge
   always @(negedge i_clk) begin
      if (o_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fails++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, o_rdata, 16'h0000);
         end else
            check(o_rdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      fails++;
      wrap_up();
   end

   initial begin
      {i_rst_n, i_cml_clear, i_user_maker_valid} = 3'h0;
      {i_user_maker_id, i_user_revision, i_vout_meas, d} = 64'h0;
      i_user_model = 8'h00;
      i_vout_mode  = 8'h14;
      seed = 16'haf70;
      fails = 0;
      total_checks = 0;
      foreach (mant[j]) mant[j] = 11'h000;
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      rd(OFF_SCRATCH, SCRATCH_RST);
      for (int r = 0; r < 4; r++) begin
         foreach (mant[j]) mant[j] = 11'(rnd());
         for (int j = 0; j < 6; j++) rd(TEL_A[j], {TEL_E[j], mant[j]});
         settle();
      end
      foreach (NMODE[k]) begin
         i_vout_mode = {3'h0, NMODE[k]};
         i_vout_meas = rnd();
         rd(OFF_VOUT, vexp(i_vout_meas, NMODE[k]));
         settle();
      end
      rd(OFF_PROTO_REV, {8'h00, PROTO_P1_REV, PROTO_P2_REV});
      rd(OFF_PART_ID, {8'h00, PART_ID_CODE});
      rd(OFF_SI_REV, {8'h00, SI_REV_CODE});
      rd(OFF_PROD_INFO, {PART_ID_CODE, SI_REV_CODE});
      rd(OFF_MODEL, {8'h00, PART_ID_CODE});
      rd(OFF_MAKER_REV, {8'h00, SI_REV_CODE});
      rd(OFF_MAKER_ID, MAKER_ID_DFLT);
      settle();
      i_user_model = 8'(rnd()) | 8'h01;
      i_user_revision = rnd() | 16'h0100;
      i_user_maker_id = rnd();
      i_user_maker_valid = 1'b1;
      d = rnd();
      rd(OFF_MODEL, {8'h00, i_user_model});
      rd(OFF_MAKER_REV, i_user_revision);
      rd(OFF_MAKER_ID, i_user_maker_id);
      wr(OFF_MAKER_ID, d);
      rd(OFF_MAKER_ID, d);
      wr(OFF_SCRATCH, ~d);
      rd(OFF_SCRATCH, ~d);
      wr(OFF_IND_PTR, {6'h00, OFF_VIN});
      rd(OFF_IND_PTR, {6'h00, OFF_VIN});
      rd(OFF_IND_DATA, {EXP_VIN, mant[0]});
      wr(OFF_IND_PTR, {6'h00, OFF_SCRATCH});
      wr(OFF_IND_DATA, d ^ 16'h00ff);
      rd(OFF_SCRATCH, d ^ 16'h00ff);
      settle();
      check({15'h0, o_cml_invalid}, 16'h0000);
      wr(OFF_VIN, 16'hffff);
      wr(OFF_PROD_INFO, 16'h0000);
      rd(OFF_PROD_INFO, {PART_ID_CODE, SI_REV_CODE});
      rd(OFF_VIN, {EXP_VIN, mant[0]});
      settle();
      check({15'h0, o_cml_invalid}, 16'h0001);
      i_cml_clear = 1'b1;
      @(posedge i_clk);
      #1;
      i_cml_clear = 1'b0;
      @(posedge i_clk);
      #1;
      check({15'h0, o_cml_invalid}, 16'h0000);
      i_vout_mode = 8'h14;
      for (int c = 0; c < 5; c++) begin
         i_ptir_host.set_pg(PG_H[c], 16'h0400, 16'h0300);
         i_vout_meas = PG_M[c];
         repeat (3) @(posedge i_clk);
         #1;
         check({15'h0, o_power_good}, {15'h0, PG_E[c]});
      end
      wrap_up();
   end
endmodule : tb_top
